// File: common/ubi_defs.svh
`ifndef UBI_DEFS_SVH
`define UBI_DEFS_SVH
// register byte offsets
`define UBI_OFS_CTRL      4'h0
`define UBI_OFS_STATUS    4'h4
`define UBI_OFS_IRQ_EN    4'h8
`define UBI_OFS_IRQ_CLR   4'hC
// control field positions
`define UBI_RX_SEL_LSB    6
`define UBI_TX_SEL_LSB    14
// status / flag bit positions
`define UBI_BIT_TX_IRQ    0
`define UBI_BIT_RX_IRQ    1
// reset values
`define UBI_CTRL_RST      32'h0000_0000
`define UBI_IRQ_EN_RST    2'h0
`endif

// File: common/ubi_pkg.sv
package ubi_pkg;
    // interrupt select encodings shared by both directions
    typedef enum logic [1:0] {
        UBI_SEL_ONE  = 2'h0,
        UBI_SEL_SEC  = 2'h1,
        UBI_SEL_THD  = 2'h2,
        UBI_SEL_RSV  = 2'h3
    } ubi_sel_t;
endpackage

// File: dv/uart_buffer_interrupt_gen_tb.sv
`timescale 1ns/1ps
`include "ubi_defs.svh"
module uart_buffer_interrupt_gen_tb;
    logic clk_in = 0, arst_n_in = 0, rd = 0, wr = 0, idle = 1, ti, irq, wq;
    logic [3:0]  adr = 0, free = 4'h8, cnt = 0, tf, rc;
    logic [31:0] wd = 0, rdat, q, e;
    int err_total = 0, total_checks = 0, v, s, i;
    // free-running clock at 4 ns
    always #2 clk_in = ~clk_in;
    ubi_peer_model i_peer (.clk_in(clk_in), .free_set_in(free),
        .idle_set_in(idle), .count_set_in(cnt), .tx_free_out(tf),
        .tx_shift_idle_out(ti), .rx_count_out(rc));
    ubi_irq_gen i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
        .tx_free_in(tf), .tx_shift_idle_in(ti), .rx_count_in(rc),
        .irq_out(irq));
    // verdict and end of run
    task stop_test;
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // compare and report
    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        // waitrequest and read data are taken at the rising edge only
        do begin @(posedge clk_in); k++; end
        while (wq !== 1'b0 && k < 50);
        q = rdat;
        if (k >= 50) err_total++;
        rd <= 0; wr <= 0;
    endtask
    task wt(input int c); repeat (c) @(posedge clk_in); endtask
    // irq level settled mid-cycle
    task ck_irq(input logic x);
        @(negedge clk_in);
        chk({31'h0, irq}, {31'h0, x});
    endtask
    // expected status after a clear while levels hold steady
    function logic [31:0] lvl(input int s, input int v);
        logic tx, rx;
        tx = (s == 0) && (v == 1);
        rx = (s == 0) ? v == 1 : (s == 1) ? v == 4 : (s == 2) && v == 6;
        return {30'h0, rx, tx};
    endfunction
    // main sequence
    initial begin
        v = $urandom(32'hA8491AF9);
        wt(20); arst_n_in <= 1; wt(3);
        bus(0, `UBI_OFS_CTRL, 0); chk(q, `UBI_CTRL_RST);
        bus(0, `UBI_OFS_IRQ_EN, 0); chk(q, 32'h0);
        bus(0, 4'h1, 0); chk(q, 32'h0);
        bus(1, `UBI_OFS_IRQ_EN, 3);
        for (s = 0; s < 4; s++) begin
            e = (32'(s) << `UBI_TX_SEL_LSB) | (32'(s) << `UBI_RX_SEL_LSB);
            bus(1, `UBI_OFS_CTRL, e); bus(0, `UBI_OFS_CTRL, 0); chk(q, e);
            for (i = 0; i < 15; i++) begin
                v = (i < 9) ? i : $urandom_range(8, 0);
                free <= v[3:0]; cnt <= v[3:0]; idle <= 1;
                wt(3); bus(1, `UBI_OFS_IRQ_CLR, 3); wt(3);
                bus(0, `UBI_OFS_STATUS, 0);
                chk(q, lvl(s, v));
                ck_irq(|lvl(s, v));
            end
        end
        // edge modes: set on the event, sticky after it passes
        for (s = 1; s < 3; s++) begin
            bus(1, `UBI_OFS_CTRL, (32'(s) << `UBI_TX_SEL_LSB));
            cnt <= 0; free <= 0; idle <= 0; wt(3);
            bus(1, `UBI_OFS_IRQ_CLR, 3);
            free <= 4'h8; idle <= 1; wt(3);
            bus(0, `UBI_OFS_STATUS, 0); chk(q, 32'h1);
            bus(1, `UBI_OFS_IRQ_CLR, 3); wt(3);
            bus(0, `UBI_OFS_STATUS, 0); chk(q, 32'h0);
            free <= 0; idle <= 0; wt(3);
            free <= 4'h8; idle <= 1; wt(3);
            free <= 0; idle <= 0; wt(3);
            bus(0, `UBI_OFS_STATUS, 0); chk(q, 32'h1);
        end
        bus(1, `UBI_OFS_IRQ_EN, 2); ck_irq(0);
        bus(1, `UBI_OFS_IRQ_EN, 1); ck_irq(1);
        bus(1, `UBI_OFS_IRQ_CLR, 1); ck_irq(0);
        stop_test;
    end
    // hang guard
    initial begin
        #100000;
        err_total++;
        stop_test;
    end
endmodule

// File: dv/ubi_peer_model.sv
`timescale 1ns/1ps
// far-side serial core: buffer levels follow the commanded targets
module ubi_peer_model (
    // clock
    input  wire logic       clk_in,
    // commanded levels
    input  wire logic [3:0] free_set_in,
    input  wire logic       idle_set_in,
    input  wire logic [3:0] count_set_in,
    // buffer state seen by the block
    output logic      [3:0] tx_free_out,
    output logic            tx_shift_idle_out,
    output logic      [3:0] rx_count_out
);
    // levels move only at the clock edge, as the core's would
    always_ff @(posedge clk_in) begin
        tx_free_out       <= free_set_in;
        tx_shift_idle_out <= idle_set_in;
        rx_count_out      <= count_set_in;
    end
endmodule

// File: src/ubi_irq_gen.sv
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "ubi_defs.svh"
// Contract
// - tx select 0: irq while one slot empty
// - rx select 0: irq while exactly one character
// - tx select 1: pulse when all shifted out
// - tx select 2: pulse when tx buffer empties
// - rx select 1: irq only at exactly half
// - rx select 2: irq only at three-quarters
module ubi_irq_gen #(
    parameter int DEPTH = 8,
    parameter int CW    = 4
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          arst_n_in,
    // avalon-mm slave
    input  wire logic [3:0]    avs_address_in,
    input  wire logic          avs_read_in,
    input  wire logic          avs_write_in,
    input  wire logic [31:0]   avs_writedata_in,
    input  wire logic [3:0]    avs_byteenable_in,
    output logic      [31:0]   avs_readdata_out,
    output logic               avs_waitrequest_out,
    // buffer state from the serial core, same clock
    input  wire logic [CW-1:0] tx_free_in,
    input  wire logic          tx_shift_idle_in,
    input  wire logic [CW-1:0] rx_count_in,
    // interrupt
    output logic               irq_out
);
    // reset synchroniser: asserts at once, releases two edges after the pin
    logic rst_meta_reg;                    // first stage, may settle late
    logic rst_n_reg;                       // released copy for the block
    // only the second stage reads the first stage
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // registers
    logic [31:0] ctrl_reg,   ctrl_next;   // select fields
    logic [1:0]  flag_reg,   flag_next;   // sticky irq flags
    logic [1:0]  en_reg,     en_next;     // irq enables
    logic        ack_reg,    ack_next;    // bus answer phase
    logic [31:0] rdata_reg,  rdata_next;  // read data
    logic        tx_done_reg;             // previous all-sent level
    logic        tx_empty_reg;            // previous buffer-empty level

    // select fields decoded from the control word, one per direction
    ubi_pkg::ubi_sel_t tx_sel;             // transmit interrupt mode
    ubi_pkg::ubi_sel_t rx_sel;             // receive interrupt mode
    assign tx_sel = ubi_pkg::ubi_sel_t'(ctrl_reg[`UBI_TX_SEL_LSB +: 2]);
    assign rx_sel = ubi_pkg::ubi_sel_t'(ctrl_reg[`UBI_RX_SEL_LSB +: 2]);

    // buffer levels: every slot free means the buffer is empty, and the
    // shifter idle on top of that means every character has gone out
    logic tx_empty, tx_done;
    assign tx_empty = (tx_free_in == CW'(DEPTH));
    assign tx_done  = tx_empty && tx_shift_idle_in;

    // one wait cycle per access, answer on the second edge
    // acc marks the first cycle of a request, wr_hit the answer cycle;
    // a write lands only at the edge where waitrequest is low
    logic acc, wr_hit;
    assign acc    = (avs_read_in || avs_write_in) && !ack_reg;
    assign wr_hit = avs_write_in && ack_reg;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
    assign avs_readdata_out    = rdata_reg;
    assign irq_out             = |(flag_reg & en_reg);

    // interrupt conditions per selected mode
    // level modes follow the buffer each cycle; edge modes fire once and
    // stay quiet after a clear while the condition persists
    logic tx_cond, rx_cond;
    always_comb begin
        case (tx_sel)
            ubi_pkg::UBI_SEL_ONE: tx_cond = (tx_free_in == CW'(1));
            ubi_pkg::UBI_SEL_SEC: tx_cond = tx_done && !tx_done_reg;
            ubi_pkg::UBI_SEL_THD: tx_cond = tx_empty && !tx_empty_reg;
            default:              tx_cond = 1'b0;
        endcase
        case (rx_sel)
            ubi_pkg::UBI_SEL_ONE: rx_cond = (rx_count_in == CW'(1));
            ubi_pkg::UBI_SEL_SEC:
                rx_cond = (rx_count_in == CW'(DEPTH / 2));
            ubi_pkg::UBI_SEL_THD:
                rx_cond = (rx_count_in == CW'(DEPTH * 3 / 4));
            default:              rx_cond = 1'b0;
        endcase
    end

    // register next values
    // bus writes first, then the hardware set terms are or-ed on top
    always_comb begin
        ctrl_next  = ctrl_reg;
        en_next    = en_reg;
        flag_next  = flag_reg;
        rdata_next = rdata_reg;
        ack_next   = acc;
        if (wr_hit && avs_byteenable_in == 4'hF) begin
            case (avs_address_in)
                `UBI_OFS_CTRL:    ctrl_next = avs_writedata_in;
                `UBI_OFS_IRQ_EN:  en_next   = avs_writedata_in[1:0];
                `UBI_OFS_IRQ_CLR:
                    flag_next = flag_reg & ~avs_writedata_in[1:0];
                default:          ctrl_next = ctrl_reg;
            endcase
        end
        // set beats clear
        flag_next[`UBI_BIT_TX_IRQ] = flag_next[`UBI_BIT_TX_IRQ] | tx_cond;
        flag_next[`UBI_BIT_RX_IRQ] = flag_next[`UBI_BIT_RX_IRQ] | rx_cond;
        // read data is caught in the wait cycle so it stands at the answer
        if (acc && avs_read_in) begin
            case (avs_address_in)
                `UBI_OFS_CTRL:   rdata_next = ctrl_reg;
                `UBI_OFS_STATUS: rdata_next = {30'h0, flag_reg};
                `UBI_OFS_IRQ_EN: rdata_next = {30'h0, en_reg};
                default:         rdata_next = 32'h0;
            endcase
        end
    end

    // state registers; edge history resets high so no edge-mode flag follows reset
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg     <= `UBI_CTRL_RST;
            en_reg       <= `UBI_IRQ_EN_RST;
            flag_reg     <= 2'h0;
            ack_reg      <= 1'b0;
            rdata_reg    <= 32'h0;
            tx_done_reg  <= 1'b1;
            tx_empty_reg <= 1'b1;
        end else begin
            ctrl_reg     <= ctrl_next;
            en_reg       <= en_next;
            flag_reg     <= flag_next;
            ack_reg      <= ack_next;
            rdata_reg    <= rdata_next;
            tx_done_reg  <= tx_done;
            tx_empty_reg <= tx_empty;
        end
    end

    // assertions: tx direction
    one_slot_tx_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (tx_sel == ubi_pkg::UBI_SEL_ONE && tx_free_in == CW'(1))
        |=> flag_reg[0]) else $error("tx one-slot flag missing");
    many_slot_tx_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (tx_sel == ubi_pkg::UBI_SEL_ONE && tx_free_in != CW'(1)
         && !flag_reg[0]) |=> !flag_reg[0])
        else $error("tx flag raised with several slots free");
    all_sent_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (tx_sel == ubi_pkg::UBI_SEL_SEC && $past(tx_done) && tx_done
         && !flag_reg[0] && tx_free_in != CW'(1))
        |=> !flag_reg[0]) else $error("tx done re-raised");
    done_edge_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (tx_sel == ubi_pkg::UBI_SEL_SEC && tx_done && !$past(tx_done))
        |=> flag_reg[0]) else $error("tx all-sent edge missed");
    empty_edge_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (tx_sel == ubi_pkg::UBI_SEL_THD && tx_empty && !$past(tx_empty))
        |=> flag_reg[0]) else $error("tx empty edge missed");
    empty_stay_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (tx_sel == ubi_pkg::UBI_SEL_THD && $past(tx_empty) && tx_empty
         && !flag_reg[0]) |=> !flag_reg[0])
        else $error("tx empty re-raised");
    // assertions: rx direction
    one_char_rx_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (rx_sel == ubi_pkg::UBI_SEL_ONE && rx_count_in == CW'(1))
        |=> flag_reg[1]) else $error("rx one-char flag missing");
    many_char_rx_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (rx_sel == ubi_pkg::UBI_SEL_ONE && rx_count_in != CW'(1)
         && !flag_reg[1]) |=> !flag_reg[1])
        else $error("rx flag raised with several chars");
    half_set_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (rx_sel == ubi_pkg::UBI_SEL_SEC && rx_count_in == CW'(DEPTH / 2))
        |=> flag_reg[1]) else $error("rx half level missed");
    half_rx_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (rx_sel == ubi_pkg::UBI_SEL_SEC && rx_count_in > CW'(DEPTH / 2)
         && !flag_reg[1]) |=> !flag_reg[1])
        else $error("rx over half raised");
    three_q_rx_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (rx_sel == ubi_pkg::UBI_SEL_THD
         && rx_count_in == CW'(DEPTH * 3 / 4)) |=> flag_reg[1])
        else $error("rx three-quarter missed");
    over_three_q_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (rx_sel == ubi_pkg::UBI_SEL_THD
         && rx_count_in > CW'(DEPTH * 3 / 4) && !flag_reg[1])
        |=> !flag_reg[1]) else $error("rx over three-quarter raised");
    // assertions: flags, interrupt line and bus answer
    flag_hold_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (flag_reg[0] && !wr_hit) |=> flag_reg[0])
        else $error("tx flag dropped");
    rx_hold_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        (flag_reg[1] && !wr_hit) |=> flag_reg[1])
        else $error("rx flag dropped");
    irq_level_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        irq_out == |(flag_reg & en_reg)) else $error("irq mismatch");
    wait_one_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_reg)
        avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("wait longer than one cycle");
    // cover points for the main scenarios
    done_edge_c: cover property (@(posedge clk_in) disable iff (!rst_n_reg)
        tx_sel == ubi_pkg::UBI_SEL_SEC && $rose(flag_reg[0]));
    tx_irq_c: cover property (@(posedge clk_in) disable iff (!rst_n_reg)
        $rose(flag_reg[0]));
    rx_irq_c: cover property (@(posedge clk_in) disable iff (!rst_n_reg)
        $rose(flag_reg[1]));
    clr_c: cover property (@(posedge clk_in) disable iff (!rst_n_reg)
        $fell(flag_reg[0]));
endmodule
